// *** hdl/cidf_regs.svh ***
// Register offsets, field positions and constants of the identifier tag and mask filter.
`ifndef CIDF_REGS_SVH
`define CIDF_REGS_SVH
`define CIDF_ADDR_W 8
`define CIDF_TAG_BYTE_ONE 8'hbc
`define CIDF_TAG_BYTE_TWO 8'hbd
`define CIDF_TAG_BYTE_THREE 8'hbe
`define CIDF_TAG_BYTE_FOUR 8'hbf
`define CIDF_MASK_BYTE_ONE 8'hc4
`define CIDF_MASK_BYTE_TWO 8'hc5
`define CIDF_MASK_BYTE_THREE 8'hc6
`define CIDF_MASK_BYTE_FOUR 8'hc7
`define CIDF_RTR_POS 2
`define CIDF_RB1_POS 1
`define CIDF_RB0_POS 0
`define CIDF_IDE_POS 0
`endif

// *** hdl/cidf_pkg.sv ***
// Types shared by the identifier tag and mask filter.
package cidf_pkg;
	typedef struct packed
	{
		logic [28:0] id;
		logic rtr;
		logic rb1;
		logic rb0;
		logic ide;
	} cidf_frame_t;

	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cidf_sfr_req_t;
endpackage

// *** hdl/cidf_compare.sv ***
// Masked comparison of a received frame against the stored tag.
`timescale 1ns/100ps
module cidf_compare
	import cidf_pkg::*;
#(
	parameter int ID_W = 29
)
(
	input wire logic [ID_W-1:0] i_tag_id,
	input wire logic [ID_W-1:0] i_mask_id,
	input wire logic [2:0] i_tag_flags,
	input wire logic [1:0] i_mask_flags,
	input wire logic i_expect_ext,
	input wire cidf_frame_t i_frame,
	output logic o_match
);
	wire [ID_W-1:0] bit_ok;
	wire rtr_ok;
	wire ide_ok;

	genvar g;
	generate
		for (g = 0; g < ID_W; g++)
		begin : g_bit
			assign bit_ok[g] = ~i_mask_id[g] | (i_frame.id[g] == i_tag_id[g]);
		end
	endgenerate

	assign rtr_ok = ~i_mask_flags[1] | (i_frame.rtr == i_tag_flags[2]);
	assign ide_ok = ~i_mask_flags[0] | (i_frame.ide == i_expect_ext);
	assign o_match = (&bit_ok) & rtr_ok & ide_ok;
endmodule

// *** hdl/cidf_filter.sv ***
// Identifier tag and mask storage for one message object, with receive filter.
`timescale 1ns/100ps
`include "cidf_regs.svh"
module cidf_filter
	import cidf_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire cidf_sfr_req_t i_sfr,
	input wire logic i_ext_format,
	input wire logic i_rx_enable,
	input wire logic i_rx_valid,
	input wire cidf_frame_t i_rx_frame,
	output logic [7:0] o_sfr_rdata,
	output logic o_rx_hit,
	output logic [28:0] o_tx_id,
	output logic o_tx_rtr,
	output logic o_tx_rb1,
	output logic o_tx_rb0
);
	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Tag and mask bytes have no reset; software must load them first.
	logic [7:0] tag_byte [4];
	logic [7:0] mask_byte [4];

	wire tag_sel = i_sfr.addr[7:2] == 6'(`CIDF_TAG_BYTE_ONE >> 2);
	wire mask_sel = i_sfr.addr[7:2] == 6'(`CIDF_MASK_BYTE_ONE >> 2);
	wire [1:0] idx = i_sfr.addr[1:0];

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sfr.wr && tag_sel)
			tag_byte[idx] <= i_sfr.wdata;
		if (i_sfr.wr && mask_sel)
			mask_byte[idx] <= i_sfr.wdata;
	end

	// The tag bytes power up unknown; the layout checks below wait until every
	// tag byte has been written once, so they never judge unloaded storage.
	logic [3:0] tag_loaded;
	wire [3:0] next_tag_loaded = tag_loaded | ({3'b000, i_sfr.wr && tag_sel} << idx);

	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			tag_loaded <= 4'h0;
		else
			tag_loaded <= next_tag_loaded;
	end

	// ----------------------------------------------------------------
	// Layout decode
	// ----------------------------------------------------------------
	// Reserved positions are stored as written, so they read back whatever
	// software left there; they never reach the comparison.
	wire [28:0] ext_tag = {tag_byte[0], tag_byte[1], tag_byte[2], tag_byte[3][7:3]};
	wire [28:0] std_tag = {18'h0, tag_byte[0], tag_byte[1][7:5]};
	wire [28:0] ext_mask = {mask_byte[0], mask_byte[1], mask_byte[2], mask_byte[3][7:3]};
	wire [28:0] std_mask = {18'h0, mask_byte[0], mask_byte[1][7:5]};
	wire [28:0] tag_id = i_ext_format ? ext_tag : std_tag;
	wire [28:0] mask_id = i_ext_format ? ext_mask : std_mask;
	wire tag_rtr = tag_byte[3][`CIDF_RTR_POS];
	wire tag_rb1 = i_ext_format & tag_byte[3][`CIDF_RB1_POS];
	wire tag_rb0 = tag_byte[3][`CIDF_RB0_POS];
	wire [1:0] mflags = {mask_byte[3][`CIDF_RTR_POS], mask_byte[3][`CIDF_IDE_POS]};
	wire match;
	wire [7:0] rd_mux = tag_sel ? tag_byte[idx] : (mask_sel ? mask_byte[idx] : 8'h00);

	cidf_compare #(.ID_W(29)) u_cmp
	(
		.i_tag_id(tag_id),
		.i_mask_id(mask_id),
		.i_tag_flags({tag_rtr, tag_rb1, tag_rb0}),
		.i_mask_flags(mflags),
		.i_expect_ext(i_ext_format),
		.i_frame(i_rx_frame),
		.o_match(match)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			o_sfr_rdata <= 8'h00;
			o_rx_hit <= 1'b0;
			o_tx_id <= 29'h0000000;
			o_tx_rtr <= 1'b0;
			o_tx_rb1 <= 1'b0;
			o_tx_rb0 <= 1'b0;
		end
		else
		begin
			o_sfr_rdata <= i_sfr.rd ? rd_mux : 8'h00;
			o_rx_hit <= i_rx_valid & i_rx_enable & match;
			o_tx_id <= tag_id;
			o_tx_rtr <= tag_rtr;
			o_tx_rb1 <= tag_rb1;
			o_tx_rb0 <= tag_rb0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_hit_needs_id;
		@(posedge i_sys_clk) disable iff (i_rst)
		o_rx_hit |-> $past(((i_rx_frame.id ^ tag_id) & mask_id) == 29'h0);
	endproperty
	a_hit_needs_id: assert property (p_hit_needs_id) else $error("hit with id mismatch");

	property p_hit_needs_enable;
		@(posedge i_sys_clk) disable iff (i_rst)
		o_rx_hit |-> $past(i_rx_enable && i_rx_valid);
	endproperty
	a_hit_needs_enable: assert property (p_hit_needs_enable) else $error("hit not enabled");

	property p_rtr_mask;
		@(posedge i_sys_clk) disable iff (i_rst)
		o_rx_hit && $past(mflags[1]) |-> $past(i_rx_frame.rtr == tag_rtr);
	endproperty
	a_rtr_mask: assert property (p_rtr_mask) else $error("rtr mismatch hit");

	property p_ide_mask;
		@(posedge i_sys_clk) disable iff (i_rst)
		o_rx_hit && $past(mflags[0]) |-> $past(i_rx_frame.ide == i_ext_format);
	endproperty
	a_ide_mask: assert property (p_ide_mask) else $error("ide mismatch hit");

	property p_zero_mask_hits;
		@(posedge i_sys_clk) disable iff (i_rst)
		i_rx_valid && i_rx_enable && mask_id == 29'h0 && mflags == 2'b00 |=> o_rx_hit;
	endproperty
	a_zero_mask_hits: assert property (p_zero_mask_hits) else $error("open mask missed");

	property p_tx_ext;
		@(posedge i_sys_clk) disable iff (i_rst)
		&tag_loaded && i_ext_format |=> o_tx_id[28:21] == $past(tag_byte[0])
			&& o_tx_id[4:0] == $past(tag_byte[3][7:3]);
	endproperty
	a_tx_ext: assert property (p_tx_ext) else $error("ext tag layout");

	property p_tx_std;
		@(posedge i_sys_clk) disable iff (i_rst)
		&tag_loaded && !i_ext_format |=> o_tx_id[10:3] == $past(tag_byte[0])
			&& o_tx_id[28:11] == 18'h0 && !o_tx_rb1;
	endproperty
	a_tx_std: assert property (p_tx_std) else $error("std tag layout");

	property p_tx_flags;
		@(posedge i_sys_clk) disable iff (i_rst)
		&tag_loaded |=> o_tx_rtr == $past(tag_byte[3][2]) && o_tx_rb0 == $past(tag_byte[3][0]);
	endproperty
	a_tx_flags: assert property (p_tx_flags) else $error("tag flag layout");

	property p_write_read;
		@(posedge i_sys_clk) disable iff (i_rst)
		i_sfr.wr && i_sfr.addr == `CIDF_TAG_BYTE_FOUR ##1 i_sfr.rd && !i_sfr.wr
			&& i_sfr.addr == `CIDF_TAG_BYTE_FOUR |=> o_sfr_rdata == $past(i_sfr.wdata, 2);
	endproperty
	a_write_read: assert property (p_write_read) else $error("tag byte four readback");

	property p_tx_ext_mid;
		@(posedge i_sys_clk) disable iff (i_rst)
		&tag_loaded && i_ext_format |=> o_tx_id[20:13] == $past(tag_byte[1])
			&& o_tx_id[12:5] == $past(tag_byte[2]);
	endproperty
	a_tx_ext_mid: assert property (p_tx_ext_mid) else $error("ext tag middle bytes");

	property p_tx_ext_rb1;
		@(posedge i_sys_clk) disable iff (i_rst)
		&tag_loaded && i_ext_format |=> o_tx_rb1 == $past(tag_byte[3][`CIDF_RB1_POS]);
	endproperty
	a_tx_ext_rb1: assert property (p_tx_ext_rb1) else $error("ext reserved tag bit");

	property p_tx_std_low;
		@(posedge i_sys_clk) disable iff (i_rst)
		&tag_loaded && !i_ext_format |=> o_tx_id[2:0] == $past(tag_byte[1][7:5]);
	endproperty
	a_tx_std_low: assert property (p_tx_std_low) else $error("std tag low bits");

	property p_hit_when_match;
		@(posedge i_sys_clk) disable iff (i_rst)
		i_rx_valid && i_rx_enable && ((i_rx_frame.id ^ tag_id) & mask_id) == 29'h0
			&& (!mflags[1] || i_rx_frame.rtr == tag_rtr)
			&& (!mflags[0] || i_rx_frame.ide == i_ext_format) |=> o_rx_hit;
	endproperty
	a_hit_when_match: assert property (p_hit_when_match) else $error("masked match missed");

	property p_disabled_no_hit;
		@(posedge i_sys_clk) disable iff (i_rst)
		!i_rx_enable |=> !o_rx_hit;
	endproperty
	a_disabled_no_hit: assert property (p_disabled_no_hit) else $error("hit while disabled");

	property p_tag4_write;
		@(posedge i_sys_clk) disable iff (i_rst)
		i_sfr.wr && i_sfr.addr == `CIDF_TAG_BYTE_FOUR |=> tag_byte[3] == $past(i_sfr.wdata);
	endproperty
	a_tag4_write: assert property (p_tag4_write) else $error("tag byte four write");

	property p_mask4_write;
		@(posedge i_sys_clk) disable iff (i_rst)
		i_sfr.wr && i_sfr.addr == `CIDF_MASK_BYTE_FOUR
			|=> mflags[1] == $past(i_sfr.wdata[`CIDF_RTR_POS])
			&& mflags[0] == $past(i_sfr.wdata[`CIDF_IDE_POS]);
	endproperty
	a_mask4_write: assert property (p_mask4_write) else $error("mask flag write");

	property p_rdata_idle;
		@(posedge i_sys_clk) disable iff (i_rst)
		!i_sfr.rd |=> o_sfr_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

	property p_rdata_unmapped;
		@(posedge i_sys_clk) disable iff (i_rst)
		i_sfr.rd && !tag_sel && !mask_sel |=> o_sfr_rdata == 8'h00;
	endproperty
	a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("unmapped read data");
endmodule

// *** testbench/cidf_node_model.sv ***
// Remote bus node model that presents received frames to the filter.
`timescale 1ns/100ps
module cidf_node_model
	import cidf_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_send,
	input wire cidf_frame_t i_frame,
	output logic o_valid,
	output cidf_frame_t o_frame
);
	initial
	begin
		o_valid = 1'b0;
		o_frame = '0;
	end
	// Between frames the fields toggle and o_valid stays low, so a stale frame can never raise a hit.
	always @(posedge i_sys_clk)
	begin
		o_valid <= i_send;
		o_frame <= i_send ? i_frame : ~o_frame;
	end
endmodule

// *** testbench/tb_can_id_tag_mask_filter.sv ***
// Self-checking bench for the identifier tag and mask filter.
`timescale 1ns/100ps
`include "cidf_regs.svh"
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin n_mismatch++; \
	$display("[FAIL] %s expected %h seen %h", n, e, s); end end
module tb_can_id_tag_mask_filter
	import cidf_pkg::*;
;
	logic i_sys_clk = 1'b0, i_rst = 1'b1, ext = 1'b0, rx_en = 1'b0, send = 1'b0;
	logic rx_valid, hit, tx_rtr, tx_rb1, tx_rb0;
	logic [7:0] rdata;
	logic [28:0] tx_id;
	logic [7:0] t[4], m[4];
	cidf_sfr_req_t sfr = '0;
	cidf_frame_t frm = '0, rx_frame;
	int n_mismatch = 0, num_checks = 0;
	initial forever #20 i_sys_clk = ~i_sys_clk;
	cidf_node_model node_u (.i_sys_clk(i_sys_clk), .i_send(send), .i_frame(frm),
		.o_valid(rx_valid), .o_frame(rx_frame));
	cidf_filter dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sfr(sfr), .i_ext_format(ext),
		.i_rx_enable(rx_en), .i_rx_valid(rx_valid), .i_rx_frame(rx_frame), .o_sfr_rdata(rdata),
		.o_rx_hit(hit), .o_tx_id(tx_id), .o_tx_rtr(tx_rtr), .o_tx_rb1(tx_rb1), .o_tx_rb0(tx_rb0));
	// ----------------------------------------
	// Register access and expectations
	// ----------------------------------------
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge i_sys_clk) sfr = '{w, ~w, a, d};
		@(negedge i_sys_clk) sfr = '0;
	endtask
	// Reserved positions read back as anything, so only defined bits are compared.
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] k);
		acc(1'b0, a, 8'h00);
		`CHK("read data", e & k, rdata & k)
	endtask
	// A write followed at once by a read of the same byte.
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] k);
		@(negedge i_sys_clk) sfr = '{1'b1, 1'b0, a, d};
		@(negedge i_sys_clk) sfr = '{1'b0, 1'b1, a, 8'h00};
		@(negedge i_sys_clk) sfr = '0;
		`CHK("readback", d & k, rdata & k)
	endtask
	function automatic logic [7:0] keep(input int b, input logic msk);
		if (ext)
			return (b == 3 && msk) ? 8'hfd : 8'hff;
		return b == 0 ? 8'hff : b == 1 ? 8'he0 : b == 2 ? 8'h00 : 8'h05;
	endfunction
	function automatic logic exp_hit();
		logic [28:0] ti, mi, fi;
		ti = ext ? {t[0], t[1], t[2], t[3][7:3]} : {18'h0, t[0], t[1][7:5]};
		mi = ext ? {m[0], m[1], m[2], m[3][7:3]} : {18'h0, m[0], m[1][7:5]};
		fi = ext ? frm.id : {18'h0, frm.id[10:0]};
		return rx_en && ((ti ^ fi) & mi) == 29'h0 && !(m[3][2] && t[3][2] != frm.rtr)
			&& !(m[3][0] && frm.ide != ext);
	endfunction
	task automatic stop_test();
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#1000000;
		n_mismatch++;
		stop_test();
	end
	initial
	begin
		void'($urandom(32'hc240));
		repeat (16) @(negedge i_sys_clk);
		i_rst = 1'b0;
		for (int k = 0; k < 60; k++)
		begin
			ext = k[0];
			rx_en = (k % 7) != 3;
			for (int b = 0; b < 4; b++)
			begin
				t[b] = 8'($urandom);
				m[b] = 8'($urandom) & keep(b, 1'b1);
				if (k % 8 == 2 || k % 8 == 5)
					m[b] = 8'h00;
				t[b] &= ext ? 8'hff : keep(b, 1'b0);
				acc(1'b1, `CIDF_TAG_BYTE_ONE + 8'(b), t[b]);
				acc(1'b1, `CIDF_MASK_BYTE_ONE + 8'(b), m[b]);
			end
			wr_rd(`CIDF_TAG_BYTE_FOUR, t[3], keep(3, 1'b0));
			for (int b = 0; b < 4; b++)
			begin
				rd(`CIDF_TAG_BYTE_ONE + 8'(b), t[b], keep(b, 1'b0));
				rd(`CIDF_MASK_BYTE_ONE + 8'(b), m[b], keep(b, 1'b1));
			end
			rd(8'hc0, 8'h00, 8'hff);
			if (ext)
			begin
				`CHK("tx id", {t[0], t[1], t[2], t[3][7:3]}, tx_id)
				`CHK("tx rb1", t[3][1], tx_rb1)
			end
			else
			begin
				`CHK("tx id", {18'h0, t[0], t[1][7:5]}, tx_id)
				`CHK("tx rb1", 1'b0, tx_rb1)
			end
			`CHK("tx rtr", t[3][2], tx_rtr)
			`CHK("tx rb0", t[3][0], tx_rb0)
			frm = '{29'($urandom), t[3][2] ^ (k % 5 == 0), 1'($urandom), 1'($urandom),
				ext ^ (k % 4 == 1)};
			if (k % 3 != 0)
				frm.id = ext ? {t[0], t[1], t[2], t[3][7:3]} : {frm.id[28:11], t[0], t[1][7:5]};
			@(negedge i_sys_clk) send = 1'b1;
			@(negedge i_sys_clk) send = 1'b0;
			@(negedge i_sys_clk);
			`CHK("rx hit", exp_hit(), hit)
		end
		stop_test();
	end
endmodule
